// ### dhc_pkg.sv
// Constants and carrier types of the holdover control register bank.
// Assumes one 100 MHz clock shared with the loop core.
package dhc_pkg;
	localparam int DHC_FTW_W   = 30;
	localparam int DHC_CLAMP_W = 20;
	localparam int DHC_TMR_W   = 16;
	localparam int DHC_SUM_W   = 46;
	localparam int DHC_IDX_W   = 11;
	localparam int DHC_NBYTES  = 18;
	localparam logic [10:0] DHC_IDX_FRW_B0  = 11'h400;
	localparam logic [10:0] DHC_IDX_FRW_B1  = 11'h401;
	localparam logic [10:0] DHC_IDX_FRW_B2  = 11'h402;
	localparam logic [10:0] DHC_IDX_FRW_B3  = 11'h403;
	localparam logic [10:0] DHC_IDX_DIV     = 11'h404;
	localparam logic [10:0] DHC_IDX_LOW_B0  = 11'h405;
	localparam logic [10:0] DHC_IDX_LOW_B1  = 11'h406;
	localparam logic [10:0] DHC_IDX_LOW_B2  = 11'h407;
	localparam logic [10:0] DHC_IDX_HIGH_B0 = 11'h408;
	localparam logic [10:0] DHC_IDX_HIGH_B1 = 11'h409;
	localparam logic [10:0] DHC_IDX_HIGH_B2 = 11'h40a;
	localparam logic [10:0] DHC_IDX_TMR_B0  = 11'h40b;
	localparam logic [10:0] DHC_IDX_TMR_B1  = 11'h40c;
	localparam logic [10:0] DHC_IDX_MODE    = 11'h40d;
	localparam logic [10:0] DHC_IDX_PHS_B0  = 11'h40e;
	localparam logic [10:0] DHC_IDX_PHS_B1  = 11'h40f;
	localparam logic [10:0] DHC_IDX_PHS_B2  = 11'h410;
	localparam logic [10:0] DHC_IDX_PHS_B3  = 11'h411;
	localparam logic [10:0] DHC_IDX_STATUS  = 11'h41f;
	localparam logic [7:0] DHC_RST_VAL [DHC_NBYTES] = '{8'h12, 8'h15, 8'h64, 8'h1b, 8'h08,
		8'h51, 8'hb8, 8'h02, 8'h3e, 8'h0a, 8'h0b, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] DHC_WR_MASK [DHC_NBYTES] = '{8'hff, 8'hff, 8'hff, 8'h3f, 8'h1f,
		8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'h1f, 8'hff, 8'hff, 8'hff, 8'h3f};
	localparam int DHC_MODE_FALLBACK = 4;
	localparam int DHC_MODE_PERSIST  = 3;
	localparam logic [4:0] DHC_DIV_MIN  = 5'h04;
	localparam logic [4:0] DHC_DIV_HOLE = 5'h05;
	localparam logic [4:0] DHC_DIV_MAX  = 5'h0f;
	localparam int DHC_STAT_VALID     = 0;
	localparam int DHC_STAT_BUSY      = 1;
	localparam int DHC_STAT_FROM_HIST = 2;
	localparam int DHC_CLK_PERIOD_PS  = 10000;
	localparam int DHC_MS_PS          = 1000000000;
	localparam int DHC_MS_CYCLES      = DHC_MS_PS / DHC_CLK_PERIOD_PS;
	typedef struct packed {
		logic        [DHC_FTW_W-1:0]   freerun;
		logic        [3:0]             osc_div;
		logic        [DHC_CLAMP_W-1:0] pull_low;
		logic        [DHC_CLAMP_W-1:0] pull_high;
		logic        [DHC_TMR_W-1:0]   timer_ms;
		logic                          fallback;
		logic                          persist;
		logic        [2:0]             incr_n;
		logic signed [DHC_FTW_W-1:0]   phase_ps;
	} dhc_cfg_s;
endpackage

// ### dhc_seq_div.sv
// Sequential restoring divider for the history average.
// Assumes a nonzero divisor and starts spaced wider than one division.
`timescale 1ns/1ps
`default_nettype none
module dhc_seq_div
	import dhc_pkg::*;
#(
	parameter int NUM_W = DHC_SUM_W,
	parameter int DEN_W = DHC_TMR_W
) (
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic             start,
	input  wire logic             abort,
	input  wire logic [NUM_W-1:0] num,
	input  wire logic [DEN_W-1:0] den,
	output logic                  busy,
	output logic                  done,
	output logic      [NUM_W-1:0] quot
);
	typedef enum logic [2:0] {
		DHC_DV_IDLE = 3'b001,
		DHC_DV_RUN  = 3'b010,
		DHC_DV_DONE = 3'b100
	} dhc_div_state_e;
	localparam int CNT_W = $clog2(NUM_W + 1);
	dhc_div_state_e   state_reg;
	logic [CNT_W-1:0] step_reg;
	logic [DEN_W:0]   rem_reg;
	logic [DEN_W-1:0] den_reg;
	logic [DEN_W:0]   rem_sh;
	assign rem_sh = {rem_reg[DEN_W-1:0], quot[NUM_W-1]};
	assign busy   = (state_reg != DHC_DV_IDLE);
	assign done   = (state_reg == DHC_DV_DONE);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= DHC_DV_IDLE;
			step_reg  <= '0;
			rem_reg   <= '0;
			den_reg   <= '0;
			quot      <= '0;
		end else begin
			case (state_reg)
				DHC_DV_IDLE: begin
					if (start && !abort) begin
						state_reg <= DHC_DV_RUN;
						step_reg  <= '0;
						rem_reg   <= '0;
						den_reg   <= den;
						quot      <= num;
					end
				end
				DHC_DV_RUN: begin
					if (rem_sh >= {1'b0, den_reg}) begin
						rem_reg <= rem_sh - {1'b0, den_reg};
						quot    <= {quot[NUM_W-2:0], 1'b1};
					end else begin
						rem_reg <= rem_sh;
						quot    <= {quot[NUM_W-2:0], 1'b0};
					end
					step_reg <= step_reg + 1'b1;
					if (abort) begin
						state_reg <= DHC_DV_IDLE;
					end else if (step_reg == CNT_W'(NUM_W - 1)) begin
						state_reg <= DHC_DV_DONE;
					end
				end
				DHC_DV_DONE: state_reg <= DHC_DV_IDLE;
				default:     state_reg <= DHC_DV_IDLE;
			endcase
		end
	end
endmodule // dhc_seq_div
`default_nettype wire

// ### dhc_hist_avg.sv
// Tuning word history: accumulates one sample per millisecond tick outside holdover.
// Assumes a divider that finishes well within one tick.
`timescale 1ns/1ps
`default_nettype none
module dhc_hist_avg
	import dhc_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic                 tick,
	input  wire logic                 holdover,
	input  wire logic                 ref_switch,
	input  wire logic [DHC_FTW_W-1:0] loop_word,
	input  wire logic [DHC_TMR_W-1:0] timer_ms,
	input  wire logic [2:0]           incr_n,
	input  wire logic                 persist,
	input  wire logic                 div_done,
	input  wire logic [DHC_FTW_W-1:0] div_quot,
	output logic                      div_start,
	output logic                      div_abort,
	output logic      [DHC_SUM_W-1:0] div_num,
	output logic      [DHC_TMR_W-1:0] div_den,
	output logic      [DHC_FTW_W-1:0] avg_word,
	output logic                      hist_valid
);
	logic [DHC_SUM_W-1:0] sum_reg;
	logic [DHC_SUM_W-1:0] sum_next;
	logic [DHC_TMR_W-1:0] cnt_reg;
	logic [DHC_TMR_W-1:0] el_next;
	logic                 first_reg;
	logic                 sample;
	logic                 full;
	logic                 early;
	assign sample    = tick && !holdover;
	assign sum_next  = sum_reg + DHC_SUM_W'(loop_word);
	assign el_next   = cnt_reg + 1'b1;
	assign full      = (el_next >= timer_ms);
	assign div_abort = ref_switch && !persist;
	always_comb begin
		early = 1'b0;
		for (int k = 1; k <= 7; k++) begin
			if (k <= int'(incr_n) && first_reg && (timer_ms >> k) != '0
				&& el_next == (timer_ms >> k)) begin
				early = 1'b1; // [R10]
			end
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sum_reg   <= '0;
			cnt_reg   <= '0;
			first_reg <= 1'b1;
			div_start <= 1'b0;
			div_num   <= '0;
			div_den   <= '0;
		end else begin
			div_start <= sample && !ref_switch && (full || early); // [R06] [R10]
			div_num   <= sum_next;
			div_den   <= el_next;
			if (ref_switch) begin
				sum_reg   <= '0;
				cnt_reg   <= '0;
				first_reg <= 1'b1;
			end else if (sample && full) begin
				sum_reg   <= '0;
				cnt_reg   <= '0;
				first_reg <= 1'b0;
			end else if (sample) begin
				sum_reg <= sum_next;
				cnt_reg <= el_next;
			end
		end
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			hist_valid <= 1'b0;
			avg_word   <= '0;
		end else if (div_abort) begin
			hist_valid <= 1'b0; // [R09]
		end else if (div_done) begin
			hist_valid <= 1'b1; // [R06]
			avg_word   <= div_quot;
		end
	end
	AST_NO_EARLY_AT_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R10]
		sample && incr_n == 3'h0 && !full |=> !div_start)
		else $error("history updated early with incremental average off");
	AST_FULL_UPDATE: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R06]
		sample && full && !ref_switch |=> div_start && div_den == $past(el_next))
		else $error("full interval did not start an average");
endmodule // dhc_hist_avg
`default_nettype wire

// ### dhc_holdover_ctrl.sv
// Holdover and free-run control bank of the first digital loop, APB slave.
// Assumes the loop core runs on ref_clk and feeds loop_word in that domain.
//
// Summary of operation
// [R01] Thirty-bit free-run word in four bytes.
// [R02] Divider code 4 or 6-15; reset 8.
// [R03] Twenty-bit lower pull-in limit, three bytes.
// [R04] Twenty-bit upper pull-in limit, three bytes.
// [R05] Sixteen-bit history timer in ms, reset 10.
// [R06] Averaged loop word used during holdover.
// [R07] Software never writes zero history timer.
// [R08] No history: bit 4 picks fallback word.
// [R09] Reference switch clears history unless persistent.
// [R10] Early updates at 1/2 to 1/2^N.
// [R11] Signed thirty-bit fixed phase offset in ps.
// [R12] Multi-byte settings apply as one word.
`timescale 1ns/1ps
`default_nettype none
module dhc_holdover_ctrl
	import dhc_pkg::*;
#(
	parameter int MS_CYCLES = DHC_MS_CYCLES,
	parameter int ADDR_W    = 13
) (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [ADDR_W-1:0]    paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [DHC_FTW_W-1:0] loop_word,
	input  wire logic                 ref_switch,
	input  wire logic                 holdover,
	output dhc_cfg_s                  cfg,
	output logic      [DHC_FTW_W-1:0] holdover_word,
	output logic                      hist_valid
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	localparam int MS_W    = $clog2(MS_CYCLES);
	localparam int SL_FRW  = int'(DHC_IDX_FRW_B0 - DHC_IDX_FRW_B0);
	localparam int SL_LOW  = int'(DHC_IDX_LOW_B0 - DHC_IDX_FRW_B0);
	localparam int SL_HIGH = int'(DHC_IDX_HIGH_B0 - DHC_IDX_FRW_B0);
	localparam int SL_TMR  = int'(DHC_IDX_TMR_B0 - DHC_IDX_FRW_B0);
	localparam int SL_PHS  = int'(DHC_IDX_PHS_B0 - DHC_IDX_FRW_B0);

	logic [DHC_IDX_W-1:0] idx;
	logic [DHC_IDX_W-1:0] slot;
	logic                 in_bank;
	logic                 is_status;
	logic                 access;
	logic                 xfer;
	logic                 div_bad;
	logic                 wr_en;
	logic                 bus_err;
	logic [7:0]           wbyte;
	logic [7:0]           rd_byte;
	logic [7:0]           status_byte;
	logic [7:0]           stage_reg [DHC_NBYTES];
	logic [MS_W-1:0]      ms_cnt_reg;
	logic                 tick_reg;
	logic [DHC_FTW_W-1:0] last_loop_reg;
	logic                 from_hist_reg;
	logic [DHC_FTW_W-1:0] avg_word;
	logic                 div_start;
	logic                 div_abort;
	logic                 div_busy;
	logic                 div_done;
	logic [DHC_SUM_W-1:0] div_num;
	logic [DHC_SUM_W-1:0] div_quot;
	logic [DHC_TMR_W-1:0] div_den;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Each byte register sits in the low lane of its own word.
	assign idx       = DHC_IDX_W'(paddr[ADDR_W-1:2]);
	assign slot      = idx - DHC_IDX_FRW_B0;
	assign in_bank   = (idx >= DHC_IDX_FRW_B0) && (idx <= DHC_IDX_PHS_B3);
	assign is_status = (idx == DHC_IDX_STATUS);
	assign access    = psel && penable;
	assign xfer      = access && pready;
	assign wbyte     = pwdata[7:0] & (in_bank ? DHC_WR_MASK[slot[4:0]] : 8'h00);
	assign div_bad   = (wbyte[4:0] < DHC_DIV_MIN) || (wbyte[4:0] == DHC_DIV_HOLE)
		|| (wbyte[4:0] > DHC_DIV_MAX); // [R02]
	// An invalid divider code is refused whole rather than stored.
	assign wr_en     = xfer && pwrite && in_bank && !(idx == DHC_IDX_DIV && div_bad);
	assign bus_err   = (!in_bank && !is_status) || (pwrite && is_status)
		|| (pwrite && idx == DHC_IDX_DIV && div_bad);

	assign status_byte = {5'h00, from_hist_reg, div_busy, hist_valid};
	assign rd_byte     = in_bank ? stage_reg[slot[4:0]] : (is_status ? status_byte : 8'h00);

	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	// One wait state keeps read data coming straight from a flop.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= access && !pready;
			pslverr <= access && !pready && bus_err;
			if (access && !pready && !pwrite) begin
				prdata <= {24'h000000, rd_byte};
			end else begin
				prdata <= '0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Staging bytes
	// ----------------------------------------------------------------
	// Reserved bits are masked on the way in, so they always read zero.
	generate
		for (genvar g = 0; g < DHC_NBYTES; g++) begin : g_stage
			always_ff @(posedge ref_clk or negedge arst_n) begin
				if (!arst_n) begin
					stage_reg[g] <= DHC_RST_VAL[g];
				end else if (wr_en && slot == DHC_IDX_W'(g)) begin
					stage_reg[g] <= wbyte; // [R01] [R03] [R04] [R11]
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Working settings
	// ----------------------------------------------------------------
	// The loop only sees a group when its top byte lands, so software
	// must write low bytes first and the top byte last.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg.freerun   <= {DHC_RST_VAL[SL_FRW+3][5:0], DHC_RST_VAL[SL_FRW+2],
				DHC_RST_VAL[SL_FRW+1], DHC_RST_VAL[SL_FRW]};
			cfg.osc_div   <= DHC_RST_VAL[SL_LOW-1][3:0];
			cfg.pull_low  <= {DHC_RST_VAL[SL_LOW+2][3:0], DHC_RST_VAL[SL_LOW+1],
				DHC_RST_VAL[SL_LOW]};
			cfg.pull_high <= {DHC_RST_VAL[SL_HIGH+2][3:0], DHC_RST_VAL[SL_HIGH+1],
				DHC_RST_VAL[SL_HIGH]};
			cfg.timer_ms  <= {DHC_RST_VAL[SL_TMR+1], DHC_RST_VAL[SL_TMR]};
			cfg.fallback  <= DHC_RST_VAL[SL_TMR+2][DHC_MODE_FALLBACK];
			cfg.persist   <= DHC_RST_VAL[SL_TMR+2][DHC_MODE_PERSIST];
			cfg.incr_n    <= DHC_RST_VAL[SL_TMR+2][2:0];
			cfg.phase_ps  <= {DHC_RST_VAL[SL_PHS+3][5:0], DHC_RST_VAL[SL_PHS+2],
				DHC_RST_VAL[SL_PHS+1], DHC_RST_VAL[SL_PHS]};
		end else if (wr_en) begin
			case (idx)
				DHC_IDX_FRW_B3: begin
					cfg.freerun <= {wbyte[5:0], stage_reg[SL_FRW+2],
						stage_reg[SL_FRW+1], stage_reg[SL_FRW]}; // [R01] [R12]
				end
				DHC_IDX_DIV: begin
					cfg.osc_div <= wbyte[3:0]; // [R02]
				end
				DHC_IDX_LOW_B2: begin
					cfg.pull_low <= {wbyte[3:0], stage_reg[SL_LOW+1],
						stage_reg[SL_LOW]}; // [R03] [R12]
				end
				DHC_IDX_HIGH_B2: begin
					cfg.pull_high <= {wbyte[3:0], stage_reg[SL_HIGH+1],
						stage_reg[SL_HIGH]}; // [R04] [R12]
				end
				DHC_IDX_TMR_B1: begin
					// A zero interval would end every interval after a single sample, so it is not applied.
					if ({wbyte, stage_reg[SL_TMR]} != 16'h0000) begin
						cfg.timer_ms <= {wbyte, stage_reg[SL_TMR]}; // [R05] [R07] [R12]
					end
				end
				DHC_IDX_MODE: begin
					cfg.fallback <= wbyte[DHC_MODE_FALLBACK]; // [R08]
					cfg.persist  <= wbyte[DHC_MODE_PERSIST]; // [R09]
					cfg.incr_n   <= wbyte[2:0]; // [R10]
				end
				DHC_IDX_PHS_B3: begin
					cfg.phase_ps <= {wbyte[5:0], stage_reg[SL_PHS+2],
						stage_reg[SL_PHS+1], stage_reg[SL_PHS]}; // [R11] [R12]
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Millisecond tick
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ms_cnt_reg <= '0;
			tick_reg   <= 1'b0;
		end else if (ms_cnt_reg == MS_W'(MS_CYCLES - 1)) begin
			ms_cnt_reg <= '0;
			tick_reg   <= 1'b1; // [R05]
		end else begin
			ms_cnt_reg <= ms_cnt_reg + 1'b1;
			tick_reg   <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// History and holdover word
	// ----------------------------------------------------------------
	dhc_hist_avg u_hist (
		.ref_clk    (ref_clk),
		.arst_n     (arst_n),
		.tick       (tick_reg),
		.holdover   (holdover),
		.ref_switch (ref_switch),
		.loop_word  (loop_word),
		.timer_ms   (cfg.timer_ms),
		.incr_n     (cfg.incr_n),
		.persist    (cfg.persist),
		.div_done   (div_done),
		.div_quot   (div_quot[DHC_FTW_W-1:0]),
		.div_start  (div_start),
		.div_abort  (div_abort),
		.div_num    (div_num),
		.div_den    (div_den),
		.avg_word   (avg_word),
		.hist_valid (hist_valid)
	);

	dhc_seq_div #(
		.NUM_W (DHC_SUM_W),
		.DEN_W (DHC_TMR_W)
	) u_div (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.start   (div_start),
		.abort   (div_abort),
		.num     (div_num),
		.den     (div_den),
		.busy    (div_busy),
		.done    (div_done),
		.quot    (div_quot)
	);

	// The last loop word is frozen in holdover, when the loop no longer tracks.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_loop_reg <= '0;
			from_hist_reg <= 1'b0;
			holdover_word <= '0;
		end else begin
			if (!holdover) begin
				last_loop_reg <= loop_word; // [R08]
			end
			from_hist_reg <= hist_valid;
			if (hist_valid) begin
				holdover_word <= avg_word; // [R06]
			end else if (cfg.fallback) begin
				holdover_word <= last_loop_reg; // [R08]
			end else begin
				holdover_word <= cfg.freerun; // [R08]
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_FRW_RESERVED: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R01]
		xfer && !pwrite && idx == DHC_IDX_FRW_B3 |-> prdata[7:6] == 2'b00)
		else $error("free-run top byte reserved bits read nonzero");
	AST_DIV_LEGAL: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R02]
		cfg.osc_div >= DHC_DIV_MIN[3:0] && cfg.osc_div != DHC_DIV_HOLE[3:0])
		else $error("oscillator divider holds an invalid code");
	AST_LOW_COHERENT: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R03]
		$changed(cfg.pull_low) |-> $past(wr_en) && $past(idx) == DHC_IDX_LOW_B2)
		else $error("lower clamp changed without its top byte write");
	AST_HIGH_RESERVED: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R04]
		xfer && !pwrite && idx == DHC_IDX_HIGH_B2 |-> prdata[7:4] == 4'h0)
		else $error("upper clamp reserved nibble read nonzero");
	AST_TIMER_NONZERO: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R07]
		cfg.timer_ms != 16'h0000)
		else $error("history timer became zero");
	AST_FALLBACK_SEL: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R08]
		!hist_valid && !cfg.fallback |=> holdover_word == $past(cfg.freerun))
		else $error("holdover word did not fall back to free-run word");
	AST_SWITCH_CLEARS: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R09]
		ref_switch && !cfg.persist |=> !hist_valid ##1 !from_hist_reg)
		else $error("history survived a non-persistent reference switch");
	AST_FRW_COHERENT: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R12]
		wr_en && idx != DHC_IDX_FRW_B3 |=> $stable(cfg.freerun))
		else $error("free-run word moved on a partial write");
	AST_PHASE_APPLY: assert property (@(posedge ref_clk) disable iff (!arst_n) // [R11]
		wr_en && idx == DHC_IDX_PHS_B3 |=> cfg.phase_ps[29:24] == $past(pwdata[5:0]))
		else $error("phase offset top bits not applied");
	AST_APB_WAIT: assert property (@(posedge ref_clk) disable iff (!arst_n)
		access && !pready |=> pready ##1 !pready)
		else $error("bus answer not given after one wait state");

	COV_HIST_VALID: cover property (@(posedge ref_clk) disable iff (!arst_n)
		$rose(hist_valid));
	COV_DIV_REFUSED: cover property (@(posedge ref_clk) disable iff (!arst_n)
		xfer && pwrite && idx == DHC_IDX_DIV && pslverr);
	COV_EARLY_UPDATE: cover property (@(posedge ref_clk) disable iff (!arst_n)
		div_start && cfg.incr_n != 3'h0 && !hist_valid);
	COV_HOLD_FALLBACK: cover property (@(posedge ref_clk) disable iff (!arst_n)
		holdover && !hist_valid && cfg.fallback);
endmodule // dhc_holdover_ctrl
`default_nettype wire

// ### dhc_holdover_ctrl_tb.sv
// Self-checking bench of the holdover control register bank.
// Assumes the bank alone on ref_clk, with a shortened millisecond tick.
`timescale 1ns/1ps
`default_nettype none
module dhc_holdover_ctrl_tb
	import dhc_pkg::*;
;
	typedef struct packed {logic rd; logic err; logic [7:0] d;} dhc_exp_s;
	logic        ref_clk, arst_n, psel, penable, pwrite, ref_switch, holdover;
	logic        pready, pslverr, hist_valid;
	logic [12:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [29:0] loop_word, holdover_word, w;
	dhc_cfg_s    cfg;
	dhc_exp_s    q[$];
	dhc_exp_s    e;
	logic [7:0]  eb [DHC_NBYTES];
	int          num_errors, cmp_count, n;

	dhc_holdover_ctrl #(.MS_CYCLES(20), .ADDR_W(13)) dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_word(loop_word),
		.ref_switch(ref_switch), .holdover(holdover), .cfg(cfg),
		.holdover_word(holdover_word), .hist_valid(hist_valid));

	always #5 ref_clk = ~ref_clk;

	// ----------------------------------------
	// Reporting and bus tasks
	// ----------------------------------------
	task complete_run();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task fail(input string m);
		num_errors++;
		$display("[ERR] %0t %s", $time, m);
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp) fail(m);
	endtask

	// The answer is noted before the request goes out, so the monitor never races it.
	task apb(input logic wr, input logic [10:0] idx, input logic [7:0] d, input logic [7:0] x,
		input logic err);
		int k;
		@(posedge ref_clk);
		q.push_back({~wr, err, x});
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'($urandom), d};
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (k >= 20) begin
			fail("no pready");
			complete_run();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_hist(input int lim);
		n = 0;
		while (hist_valid !== 1'b1 && n < lim) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= lim) begin
			fail("history never valid");
			complete_run();
		end
	endtask

	task pulse_switch();
		@(posedge ref_clk);
		ref_switch <= 1'b1;
		@(posedge ref_clk);
		ref_switch <= 1'b0;
		repeat (2) @(posedge ref_clk);
	endtask

	always @(posedge ref_clk) begin
		if (pready === 1'b1) begin
			if (q.size() == 0) begin
				fail("stray response");
			end else begin
				e = q.pop_front();
				chk({31'h0, pslverr}, {31'h0, e.err}, "apb error");
				chk(prdata, {24'h0, e.d & {8{e.rd}}}, "apb data");
			end
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h4ddd));
		ref_clk = 1'b0; arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = '0; pwdata = '0; ref_switch = 1'b0; holdover = 1'b0;
		num_errors = 0; cmp_count = 0;
		w = 30'($urandom);
		loop_word = w;
		repeat (5) @(posedge ref_clk);
		arst_n <= 1'b1;
		for (int i = 0; i < DHC_NBYTES; i++) begin
			apb(1'b0, DHC_IDX_FRW_B0 + 11'(i), 8'h00, DHC_RST_VAL[i], 1'b0);
		end
		wait_hist(400);
		repeat (2) @(posedge ref_clk);
		chk({2'b00, holdover_word}, {2'b00, w}, "average word");
		for (int i = 0; i < DHC_NBYTES; i++) begin
			eb[i] = 8'($urandom);
			if (i == 4) eb[i] = 8'(6 + $urandom % 10);
			if (i == 11) eb[i][0] = 1'b1; // The timer is never left at zero.
			apb(1'b1, DHC_IDX_FRW_B0 + 11'(i), eb[i], 8'h00, 1'b0);
			eb[i] = eb[i] & DHC_WR_MASK[i];
			if (i == 2) chk({2'b00, cfg.freerun}, 32'h1b641512, "partial word");
		end
		for (int i = 0; i < DHC_NBYTES; i++) begin
			apb(1'b0, DHC_IDX_FRW_B0 + 11'(i), 8'h00, eb[i], 1'b0);
		end
		chk({2'b00, cfg.freerun}, {2'b00, eb[3][5:0], eb[2], eb[1], eb[0]}, "freerun");
		chk({12'h0, cfg.pull_low}, {12'h0, eb[7][3:0], eb[6], eb[5]}, "low clamp");
		chk({12'h0, cfg.pull_high}, {12'h0, eb[10][3:0], eb[9], eb[8]}, "high clamp");
		chk({16'h0, cfg.timer_ms}, {16'h0, eb[12], eb[11]}, "timer");
		chk({2'b00, cfg.phase_ps}, {2'b00, eb[17][5:0], eb[16], eb[15], eb[14]}, "phase");
		chk({27'h0, cfg.fallback, cfg.persist, cfg.incr_n}, {27'h0, eb[13][4:0]}, "mode");
		for (int c = 0; c < 32; c++) begin
			apb(1'b1, DHC_IDX_DIV, 8'(c), 8'h00, !(c == 4 || (c >= 6 && c <= 15)));
		end
		apb(1'b0, DHC_IDX_DIV, 8'h00, 8'h0f, 1'b0);
		chk({28'h0, cfg.osc_div}, 32'h0000000f, "divider");
		apb(1'b1, DHC_IDX_STATUS, 8'hff, 8'h00, 1'b1);
		apb(1'b0, 11'h3ff, 8'h00, 8'h00, 1'b1);
		apb(1'b1, 11'h412, 8'h55, 8'h00, 1'b1);
		apb(1'b1, DHC_IDX_TMR_B0, 8'h04, 8'h00, 1'b0);
		apb(1'b1, DHC_IDX_TMR_B1, 8'h00, 8'h00, 1'b0);
		apb(1'b1, DHC_IDX_MODE, 8'h08, 8'h00, 1'b0);
		wait_hist(400);
		pulse_switch();
		chk({31'h0, hist_valid}, 32'h1, "history kept");
		apb(1'b1, DHC_IDX_MODE, 8'h00, 8'h00, 1'b0);
		pulse_switch();
		chk({31'h0, hist_valid}, 32'h0, "history cleared");
		chk({2'b00, holdover_word}, {2'b00, eb[3][5:0], eb[2], eb[1], eb[0]}, "fallback 0");
		apb(1'b0, DHC_IDX_STATUS, 8'h00, 8'h00, 1'b0);
		apb(1'b1, DHC_IDX_MODE, 8'h10, 8'h00, 1'b0);
		repeat (2) @(posedge ref_clk);
		chk({2'b00, holdover_word}, {2'b00, w}, "fallback 1");
		// In holdover the loop word moves, but the fallback word must stay frozen.
		holdover <= 1'b1;
		@(posedge ref_clk);
		loop_word <= ~w;
		repeat (3) @(posedge ref_clk);
		chk({2'b00, holdover_word}, {2'b00, w}, "frozen word");
		holdover  <= 1'b0;
		loop_word <= w;
		apb(1'b1, DHC_IDX_TMR_B0, 8'h08, 8'h00, 1'b0);
		apb(1'b1, DHC_IDX_TMR_B1, 8'h00, 8'h00, 1'b0);
		apb(1'b1, DHC_IDX_MODE, 8'h01, 8'h00, 1'b0);
		pulse_switch();
		wait_hist(300);
		// A full interval would need well over 175 cycles; only the half-point update fits.
		chk(32'(n < 175), 32'h1, "early update");
		apb(1'b0, DHC_IDX_STATUS, 8'h00, 8'h05, 1'b0);
		chk({2'b00, holdover_word}, {2'b00, w}, "early average");
		// One more edge lets the monitor check the last bus answer first.
		@(posedge ref_clk);
		complete_run();
	end
endmodule // dhc_holdover_ctrl_tb
`default_nettype wire
